// [hdl/mss_status_regs.vh]
// register offsets, field positions and reset values of the motor status bank
`ifndef MSS_STATUS_REGS_VH
`define MSS_STATUS_REGS_VH

`define MSS_ADDR_W 7
`define MSS_DATA_W 16

`define MSS_OFS_WAKE_LEVEL 7'h45
`define MSS_OFS_HS_FAULT 7'h46
`define MSS_OFS_BRIDGE_GEN 7'h50

`define MSS_RST_WAKE_LEVEL 16'h0000
`define MSS_RST_HS_FAULT 16'h0000
`define MSS_RST_BRIDGE_GEN 16'h0000

`define MSS_WAKE_LSB 0
`define MSS_HS_OC_LSB 0
`define MSS_HS_OL_LSB 5
`define MSS_HS_OT_LSB 10
`define MSS_BR_VOUT_LSB 6
`define MSS_PWM_LSB 0

`define MSS_BR_MODE_COMPARE 2'h3

`define MSS_MODE_W 3
`define MSS_MODE_NORMAL 3'h0
`define MSS_MODE_STOP 3'h1
`define MSS_MODE_INIT 3'h2
`define MSS_MODE_RESTART 3'h3
`define MSS_MODE_SLEEP 3'h4
`define MSS_MODE_FAILSAFE 3'h5

`endif

// [hdl/mss_status_bank.v]
// status register bank: wake levels, high-side faults, bridge general status
`include "mss_status_regs.vh"
`default_nettype none

// Overview of operation
// - The wake level register follows the wake pins in normal, stop, init and restart modes.
// - In cyclic sense or wake operation the wake levels are only refreshed on each sample event.
// - Bits 4 to 0 of the wake level register show wake pins five to one, 1 for high.
// - Bits 13 to 10 hold sticky read-to-clear overtemperature flags of high sides four to one.
// - Bits 8 to 5 hold sticky read-to-clear open-load flags of high sides four to one.
// - Bits 3 to 0 hold sticky read-to-clear overcurrent flags of high sides four to one.
// - Every reserved bit of the three registers reads as zero.
// - A bridge output bit reads the sense comparator when its mode is 11 and the pump is on.
// - A bridge output bit reads zero when the pump is off or its mode is not 11.
module mss_status_bank (
  input wire mclk_i,
  input wire rst_i,
  input wire rd_stb_i,
  input wire [`MSS_ADDR_W-1:0] rd_addr_i,
  output reg [`MSS_DATA_W-1:0] rd_data_o,
  output reg rd_valid_o,
  input wire [`MSS_MODE_W-1:0] dev_mode_i,
  input wire cyclic_active_i,
  input wire cyclic_sample_i,
  input wire [4:0] wake_pin_i,
  input wire [3:0] high_side_overtemp_i,
  input wire [3:0] high_side_open_load_i,
  input wire [3:0] high_side_overcurrent_i,
  input wire charge_pump_on_i,
  input wire [7:0] bridge_mode_field_i,
  input wire [3:0] bridge_high_side_sense_i,
  input wire [3:0] pulse_input_level_i,
  output wire [`MSS_DATA_W-1:0] wake_input_level_status_o,
  output wire [`MSS_DATA_W-1:0] high_side_fault_status_o
);

  // pin levels after the two-flop synchronisers
  wire [4:0] wake_sync;
  wire [3:0] sense_sync;
  wire [3:0] pwm_sync;

  // captured register fields
  wire [4:0] wake_lvl;
  wire [3:0] ot_flags;
  wire [3:0] ol_flags;
  wire [3:0] oc_flags;
  wire [3:0] vout_lvl;
  wire [3:0] pwm_lvl;

  // register images and read mux
  reg [`MSS_DATA_W-1:0] wake_reg;
  reg [`MSS_DATA_W-1:0] hs_reg;
  reg [`MSS_DATA_W-1:0] gen_reg;
  reg [`MSS_DATA_W-1:0] rd_data_d;
  wire sel_wake;
  wire sel_hs;
  wire sel_gen;
  wire live_mode;
  wire wake_upd;
  wire hs_clr;
  genvar g;

  // one address compare, shared by the clear strobe and the read mux
  function addr_hit;
    input [`MSS_ADDR_W-1:0] addr;
    input [`MSS_ADDR_W-1:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  // modes in which the wake levels follow the pins
  function mode_is_live;
    input [`MSS_MODE_W-1:0] mode;
    begin
      case (mode)
        `MSS_MODE_NORMAL: mode_is_live = 1'b1;
        `MSS_MODE_STOP: mode_is_live = 1'b1;
        `MSS_MODE_INIT: mode_is_live = 1'b1;
        `MSS_MODE_RESTART: mode_is_live = 1'b1;
        default: mode_is_live = 1'b0;
      endcase
    end
  endfunction

  // comparator level only counts in compare mode with the pump running
  function bridge_level;
    input pump_on;
    input [1:0] mode;
    input sense;
    begin
      bridge_level = pump_on && (mode == `MSS_BR_MODE_COMPARE) && sense;
    end
  endfunction

  // set wins over clear, so a fault in the read cycle is not lost
  function sticky_next;
    input flag;
    input fault;
    input clr;
    begin
      sticky_next = fault | (flag & ~clr);
    end
  endfunction

  assign sel_wake = addr_hit(rd_addr_i, `MSS_OFS_WAKE_LEVEL);
  assign sel_hs = addr_hit(rd_addr_i, `MSS_OFS_HS_FAULT);
  assign sel_gen = addr_hit(rd_addr_i, `MSS_OFS_BRIDGE_GEN);
  assign live_mode = mode_is_live(dev_mode_i);
  // in cyclic operation the pin is only valid at the sample instant
  assign wake_upd = cyclic_active_i ? cyclic_sample_i : live_mode;
  assign hs_clr = rd_stb_i && sel_hs;

  // pins are asynchronous: two flops per bit keep metastability out
  generate
    for (g = 0; g < 5; g = g + 1) begin : wake_sync_bit
      reg s1_q;
      reg s2_q;
      always @(posedge mclk_i) begin
        if (rst_i) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= wake_pin_i[g];
          s2_q <= s1_q;
        end
      end
      assign wake_sync[g] = s2_q;
    end
  endgenerate

  generate
    for (g = 0; g < 4; g = g + 1) begin : sense_sync_bit
      reg s1_q;
      reg s2_q;
      always @(posedge mclk_i) begin
        if (rst_i) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= bridge_high_side_sense_i[g];
          s2_q <= s1_q;
        end
      end
      assign sense_sync[g] = s2_q;
    end
  endgenerate

  generate
    for (g = 0; g < 4; g = g + 1) begin : pwm_sync_bit
      reg s1_q;
      reg s2_q;
      always @(posedge mclk_i) begin
        if (rst_i) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= pulse_input_level_i[g];
          s2_q <= s1_q;
        end
      end
      assign pwm_sync[g] = s2_q;
    end
  endgenerate

  // between updates the last captured level holds
  generate
    for (g = 0; g < 5; g = g + 1) begin : wake_cap_bit
      reg lvl_q;
      always @(posedge mclk_i) begin
        if (rst_i) begin
          lvl_q <= 1'b0;
        end else if (wake_upd) begin
          lvl_q <= wake_sync[g];
        end
      end
      assign wake_lvl[g] = lvl_q;
    end
  endgenerate

  // a flag stays set until its register is read
  generate
    for (g = 0; g < 4; g = g + 1) begin : ot_flag_bit
      reg flag_q;
      always @(posedge mclk_i) begin
        if (rst_i) begin
          flag_q <= 1'b0;
        end else begin
          flag_q <= sticky_next(flag_q, high_side_overtemp_i[g], hs_clr);
        end
      end
      assign ot_flags[g] = flag_q;
    end
  endgenerate

  generate
    for (g = 0; g < 4; g = g + 1) begin : ol_flag_bit
      reg flag_q;
      always @(posedge mclk_i) begin
        if (rst_i) begin
          flag_q <= 1'b0;
        end else begin
          flag_q <= sticky_next(flag_q, high_side_open_load_i[g], hs_clr);
        end
      end
      assign ol_flags[g] = flag_q;
    end
  endgenerate

  generate
    for (g = 0; g < 4; g = g + 1) begin : oc_flag_bit
      reg flag_q;
      always @(posedge mclk_i) begin
        if (rst_i) begin
          flag_q <= 1'b0;
        end else begin
          flag_q <= sticky_next(flag_q, high_side_overcurrent_i[g], hs_clr);
        end
      end
      assign oc_flags[g] = flag_q;
    end
  endgenerate

  // pump and mode come from this clock, so only the sense pin is synchronised
  generate
    for (g = 0; g < 4; g = g + 1) begin : vout_cap_bit
      reg lvl_q;
      always @(posedge mclk_i) begin
        if (rst_i) begin
          lvl_q <= 1'b0;
        end else begin
          lvl_q <= bridge_level(charge_pump_on_i, bridge_mode_field_i[2*g +: 2],
                                sense_sync[g]);
        end
      end
      assign vout_lvl[g] = lvl_q;
    end
  endgenerate

  generate
    for (g = 0; g < 4; g = g + 1) begin : pwm_cap_bit
      reg lvl_q;
      always @(posedge mclk_i) begin
        if (rst_i) begin
          lvl_q <= 1'b0;
        end else begin
          lvl_q <= pwm_sync[g];
        end
      end
      assign pwm_lvl[g] = lvl_q;
    end
  endgenerate

  // reserved positions keep the zero of the reset image
  always @* begin
    wake_reg = `MSS_RST_WAKE_LEVEL;
    wake_reg[`MSS_WAKE_LSB +: 5] = wake_lvl;
  end

  always @* begin
    hs_reg = `MSS_RST_HS_FAULT;
    hs_reg[`MSS_HS_OT_LSB +: 4] = ot_flags;
    hs_reg[`MSS_HS_OL_LSB +: 4] = ol_flags;
    hs_reg[`MSS_HS_OC_LSB +: 4] = oc_flags;
  end

  always @* begin
    gen_reg = `MSS_RST_BRIDGE_GEN;
    gen_reg[`MSS_BR_VOUT_LSB +: 4] = vout_lvl;
    gen_reg[`MSS_PWM_LSB +: 4] = pwm_lvl;
  end

  // unmapped addresses read as zero
  always @* begin
    rd_data_d = 16'h0000;
    if (sel_wake) begin
      rd_data_d = wake_reg;
    end
    if (sel_hs) begin
      rd_data_d = hs_reg;
    end
    if (sel_gen) begin
      rd_data_d = gen_reg;
    end
  end

  // read data shows the flags as they stood before the clear
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rd_data_o <= 16'h0000;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_stb_i;
      if (rd_stb_i) begin
        rd_data_o <= rd_data_d;
      end
    end
  end

  assign wake_input_level_status_o = wake_reg;
  assign high_side_fault_status_o = hs_reg;

endmodule
`default_nettype wire

// [verification/mss_mcu_model.sv]
// microcontroller model issuing status reads
`default_nettype none
module mss_mcu_model (
  input wire logic mclk_i,
  input wire logic rd_valid_i,
  input wire logic [15:0] rd_data_i,
  output var logic rd_stb_o = 1'b0,
  output var logic [6:0] rd_addr_o = 7'h7f
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    rd_stb_o <= 1'b1;
    rd_addr_o <= a;
    @(posedge mclk_i);
    rd_stb_o <= 1'b0;
    // inverted so a stale address never passes
    rd_addr_o <= ~a;
    @(posedge mclk_i);
    d = rd_valid_i ? rd_data_i : 16'hxxxx;
  endtask
endmodule
`default_nettype wire

// [verification/mss_status_checker.sv]
// read port and flag assertions
`include "mss_status_regs.vh"
`default_nettype none
module mss_status_checker (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic rd_stb_i,
  input wire logic [6:0] rd_addr_i,
  input wire logic [15:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic [3:0] high_side_overcurrent_i,
  input wire logic [15:0] wake_input_level_status_o,
  input wire logic [15:0] high_side_fault_status_o
);
  wire [15:0] hs = high_side_fault_status_o;
  wire [15:0] wk = wake_input_level_status_o;
  wire hs_rd = rd_stb_i && rd_addr_i == `MSS_OFS_HS_FAULT;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence hs_s; hs_rd ##1 rd_valid_o; endsequence
  sequence wk_s; rd_stb_i && rd_addr_i == `MSS_OFS_WAKE_LEVEL ##1 rd_valid_o; endsequence
  valid_pulse_a: assert property (rd_stb_i |=> rd_valid_o) else $error("no answer");
  valid_only_a: assert property (!rd_stb_i |=> !rd_valid_o) else $error("stray valid");
  wake_resv_a: assert property (wk[15:5] == 11'h000) else $error("wake resv");
  fault_resv_a: assert property ({hs[15:14], hs[9], hs[4]} == 4'h0) else $error("resv");
  oc_set_a: assert property (1 |=> (hs[3:0] & $past(high_side_overcurrent_i))
    == $past(high_side_overcurrent_i)) else $error("oc lost");
  flag_keep_a: assert property (!hs_rd |=> (hs & $past(hs)) == $past(hs)) else $error("lost");
  fault_read_a: assert property (hs_s |-> rd_data_o == $past(hs)) else $error("hs read");
  wake_read_a: assert property (wk_s |-> rd_data_o == $past(wk)) else $error("wk read");
endmodule
bind mss_status_bank mss_status_checker chk (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .rd_stb_i(rd_stb_i),
  .rd_addr_i(rd_addr_i),
  .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o),
  .high_side_overcurrent_i(high_side_overcurrent_i),
  .wake_input_level_status_o(wake_input_level_status_o),
  .high_side_fault_status_o(high_side_fault_status_o)
);
`default_nettype wire

// [verification/mss_status_bank_tb.sv]
// self-checking bench for the status bank
`include "mss_status_regs.vh"
`default_nettype none
module mss_status_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = '0, rst_i = '1, rd_stb_i, rd_valid_o, cyclic_active_i = '0;
  logic cyclic_sample_i = '0, charge_pump_on_i = '0;
  logic [6:0] rd_addr_i;
  logic [15:0] rd_data_o, wake_input_level_status_o, high_side_fault_status_o, d;
  logic [2:0] dev_mode_i = '0;
  logic [4:0] wake_pin_i = '0;
  logic [3:0] high_side_overtemp_i = '0, high_side_open_load_i = '0;
  logic [3:0] high_side_overcurrent_i = '0, bridge_high_side_sense_i = '0;
  logic [3:0] pulse_input_level_i = '0;
  logic [7:0] bridge_mode_field_i = '0;
  int num_errors = 0, n_tests = 0;
  always #20 mclk_i = ~mclk_i;
  mss_status_bank DUT (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .rd_stb_i(rd_stb_i),
    .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .dev_mode_i(dev_mode_i),
    .cyclic_active_i(cyclic_active_i),
    .cyclic_sample_i(cyclic_sample_i),
    .wake_pin_i(wake_pin_i),
    .high_side_overtemp_i(high_side_overtemp_i),
    .high_side_open_load_i(high_side_open_load_i),
    .high_side_overcurrent_i(high_side_overcurrent_i),
    .charge_pump_on_i(charge_pump_on_i),
    .bridge_mode_field_i(bridge_mode_field_i),
    .bridge_high_side_sense_i(bridge_high_side_sense_i),
    .pulse_input_level_i(pulse_input_level_i),
    .wake_input_level_status_o(wake_input_level_status_o),
    .high_side_fault_status_o(high_side_fault_status_o)
  );
  mss_mcu_model mcu (.mclk_i(mclk_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
    .rd_stb_o(rd_stb_i), .rd_addr_o(rd_addr_i));
  task automatic rc(input logic [6:0] a, input logic [15:0] e);
    mcu.rd(a, d);
    n_tests++;
    if (d !== e) begin
      num_errors++;
      $display("Error %0t: reg %h read %h want %h", $time, a, d, e);
    end
  endtask
  task automatic settle;
    repeat (4) @(posedge mclk_i);
  endtask
  task automatic t_wake;
    for (int i = 0; i < 4; i++) begin
      dev_mode_i <= 3'(i);
      wake_pin_i <= 5'h10 + 5'(i);
      settle();
      rc(`MSS_OFS_WAKE_LEVEL, 16'h0010 + 16'(i));
    end
    // cyclic sampling holds until the sample pulse, even in a live mode
    dev_mode_i <= `MSS_MODE_NORMAL;
    cyclic_active_i <= 1'b1;
    wake_pin_i <= 5'h0a;
    settle();
    rc(`MSS_OFS_WAKE_LEVEL, 16'h0013);
    cyclic_sample_i <= 1'b1;
    @(posedge mclk_i);
    cyclic_sample_i <= 1'b0;
    rc(`MSS_OFS_WAKE_LEVEL, 16'h000a);
    // outside the live modes the level is not followed
    cyclic_active_i <= 1'b0;
    dev_mode_i <= `MSS_MODE_FAILSAFE;
    wake_pin_i <= 5'h15;
    settle();
    rc(`MSS_OFS_WAKE_LEVEL, 16'h000a);
  endtask
  task automatic t_fault;
    rc(`MSS_OFS_HS_FAULT, 16'h0000);
    high_side_overtemp_i <= 4'h3;
    high_side_open_load_i <= 4'ha;
    high_side_overcurrent_i <= 4'h5;
    @(posedge mclk_i);
    high_side_overtemp_i <= 4'h0;
    high_side_open_load_i <= 4'h0;
    high_side_overcurrent_i <= 4'h8;
    rc(`MSS_OFS_HS_FAULT, 16'h0d4d);
    rc(`MSS_OFS_HS_FAULT, 16'h0008);
    high_side_overcurrent_i <= 4'h0;
    rc(`MSS_OFS_HS_FAULT, 16'h0008);
    rc(`MSS_OFS_HS_FAULT, 16'h0000);
  endtask
  task automatic t_bridge;
    charge_pump_on_i <= 1'b1;
    bridge_mode_field_i <= 8'hf3;
    bridge_high_side_sense_i <= 4'h6;
    pulse_input_level_i <= 4'h9;
    settle();
    rc(`MSS_OFS_BRIDGE_GEN, 16'h0109);
    charge_pump_on_i <= 1'b0;
    settle();
    rc(`MSS_OFS_BRIDGE_GEN, 16'h0009);
    rc(7'h00, 16'h0000);
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_fault();
    t_wake();
    t_bridge();
    tally_and_finish();
  end
endmodule
`default_nettype wire
